// [rtl/rws_pkg.sv]
// Purpose: shared constants and types of the register window select block
// Assumes: 8-bit direct addresses, 16-bit memory addresses
// Notes: register offsets are byte addresses on the wishbone slave

package rws_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam logic [7:0] WSR_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] WSR_RESET = 8'h00;
  localparam int HOLD_BIT = 7;
  localparam logic [6:0] FIELD_MASK = 7'h7F;

  // ---------------------------------------------------------------
  // window geometry
  // ---------------------------------------------------------------
  localparam int SEL32_BIT = 6;
  localparam int SEL64_BIT = 5;
  localparam int SEL128_BIT = 4;
  localparam int IDX_W = 11;
  localparam logic [15:0] WIN_RAM_BASE = 16'h1800;
  localparam logic [7:0] BASE_32 = 8'hE0;
  localparam logic [7:0] BASE_64 = 8'hC0;
  localparam logic [7:0] BASE_128 = 8'h80;

  // status register fields
  localparam int STAT_BASE_LSB = 8;

  typedef enum logic [1:0] {
    RWS_NONE,
    RWS_W32,
    RWS_W64,
    RWS_W128
  } rws_size_e;

  typedef struct packed {
    logic hit;
    rws_size_e size;
    logic [15:0] addr;
  } rws_xlate_s;

endpackage : rws_pkg

// [rtl/rws_xlate.sv]
// Purpose: direct address to memory address translation
// Assumes: field is the low seven bits of the window select register
// Notes: purely combinational, the top registers the result

`timescale 1ns/1ps

module rws_xlate (
  input wire logic [6:0] field,
  input wire logic [7:0] direct_addr,
  output rws_pkg::rws_xlate_s res,
  output logic [7:0] win_base
);
  import rws_pkg::*;

  logic [IDX_W-1:0] idx;

  // ---------------------------------------------------------------
  // size decode, first set bit from the top wins
  // ---------------------------------------------------------------
  always_comb begin
    res = '0;
    win_base = '0;
    idx = '0;
    if (field[SEL32_BIT]) begin // RQ2
      res.size = RWS_W32;
      win_base = BASE_32;
      idx = {field[5:0], direct_addr[4:0]};
    end else if (field[SEL64_BIT]) begin // RQ3
      res.size = RWS_W64;
      win_base = BASE_64;
      idx = {field[4:0], direct_addr[5:0]};
    end else if (field[SEL128_BIT]) begin // RQ4
      res.size = RWS_W128;
      win_base = BASE_128;
      idx = {field[3:0], direct_addr[6:0]};
    end
    // no window: plain lower register file
    res.hit = (res.size != RWS_NONE) && (direct_addr >= win_base); // RQ12
    // number*size+offset packs into idx, so a sum is exact
    if (res.hit) begin
      res.addr = WIN_RAM_BASE + {5'h00, idx}; // RQ11 RQ1
    end else begin
      res.addr = {8'h00, direct_addr};
    end
  end

endmodule : rws_xlate

// [rtl/rws_wsr.sv]
// Purpose: window select register storage
// Assumes: pop restore and bus write are one-cycle strobes
// Notes: restore wins over a bus write in the same cycle

`timescale 1ns/1ps

module rws_wsr #(
  parameter bit HOLD_PRESENT = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_wr,
  input wire logic [7:0] bus_data,
  input wire logic pop_wr,
  input wire logic [7:0] pop_data,
  output logic [7:0] wsr_q
);
  import rws_pkg::*;

  logic [7:0] wsr_d;
  logic [7:0] keep_mask;

  // ---------------------------------------------------------------
  // next value
  // ---------------------------------------------------------------
  always_comb begin
    // without bus-hold the top bit is reserved and held at zero
    keep_mask = {HOLD_PRESENT, FIELD_MASK}; // RQ9
    wsr_d = wsr_q;
    if (pop_wr) begin
      wsr_d = pop_data & keep_mask; // RQ10
    end else if (bus_wr) begin
      wsr_d = bus_data & keep_mask;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wsr_q <= WSR_RESET;
    end else begin
      wsr_q <= wsr_d;
    end
  end

  property p_pop_restore;
    @(posedge mclk) disable iff (reset)
      pop_wr |=> wsr_q == ($past(pop_data) & $past(keep_mask));
  endproperty
  a_pop_restore: assert property (p_pop_restore) // RQ10
    else $error("pop did not restore window select");

endmodule : rws_wsr

// [rtl/rws_top.sv]
// Purpose: register window select block with wishbone slave
// Assumes: core request and strobes synchronous to mclk
// Notes: translation answers one cycle after the request
//
// The implementer's own choice: the Wishbone interface to the registers.

`timescale 1ns/1ps

// Functional notes
// RQ1 - map RAM section into upper register file
// RQ2 - field bit 6 set: 32-byte window
// RQ3 - top bits 01: 64-byte window
// RQ4 - top bits 001: 128-byte window
// RQ5 - 1E00H seen at E0/C0/80 per selector
// RQ6 - 1FACH seen at ECH or ACH
// RQ7 - 1E4FH seen at EFH or CFH
// RQ8 - bit 7 enables bus-hold, not mapping
// RQ9 - software writes bit 7 zero if absent
// RQ10 - push saves, pop restores the register
// RQ11 - address = 1800H + number*size + offset
// RQ12 - no window when top three bits zero
module rws_top #(
  parameter bit HOLD_PRESENT = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rws_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [rws_pkg::DAT_W-1:0] wb_dat_i,
  output logic [rws_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic core_req,
  input wire logic [7:0] core_addr,
  output rws_pkg::rws_xlate_s xlate_q,
  output logic xlate_vld_q,
  input wire logic push_all_instr,
  input wire logic pop_all_instr,
  input wire logic [7:0] pop_data,
  output logic [7:0] push_data_q,
  output logic push_vld_q,
  output logic hold_protocol_enable_q,
  output logic [7:0] window_select_reg
);
  import rws_pkg::*;

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic ack_d;
  logic [DAT_W-1:0] rdata_d;
  logic wsr_wr;
  logic [7:0] wsr_q;
  rws_xlate_s xl;
  logic [7:0] win_base;
  logic [DAT_W-1:0] stat_word;

  // a write lands on the edge where the master sees ack
  assign wsr_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                  && (wb_adr_i == WSR_OFS) && wb_sel_i[0];

  always_comb begin
    // ack is dropped for one cycle after each answer
    ack_d = wb_cyc_i && wb_stb_i && !wb_ack_o;
    stat_word = '0;
    stat_word[1:0] = xl.size;
    stat_word[STAT_BASE_LSB +: 8] = win_base;
    rdata_d = '0;
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        WSR_OFS: rdata_d = {24'h000000, wsr_q};
        STAT_OFS: rdata_d = stat_word;
        // unmapped reads answer zero
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  rws_wsr #(
    .HOLD_PRESENT(HOLD_PRESENT)
  ) u_wsr (
    .mclk(mclk),
    .reset(reset),
    .bus_wr(wsr_wr),
    .bus_data(wb_dat_i[7:0]),
    .pop_wr(pop_all_instr), // RQ10
    .pop_data(pop_data),
    .wsr_q(wsr_q)
  );

  assign window_select_reg = wsr_q;

  // ---------------------------------------------------------------
  // translation
  // ---------------------------------------------------------------
  rws_xlate u_xlate (
    .field(wsr_q[6:0]),
    .direct_addr(core_addr),
    .res(xl),
    .win_base(win_base)
  );

  rws_xlate_s xlate_d;
  logic xlate_vld_d;
  logic [7:0] push_data_d;
  logic push_vld_d;
  logic hold_d;

  always_comb begin
    // result holds between requests
    xlate_d = core_req ? xl : xlate_q; // RQ1
    xlate_vld_d = core_req;
    push_vld_d = push_all_instr;
    push_data_d = push_all_instr ? wsr_q : push_data_q; // RQ10
    // hold bit is not fed to the window decode
    hold_d = HOLD_PRESENT && wsr_q[HOLD_BIT]; // RQ8
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      xlate_q <= '0;
      xlate_vld_q <= 1'b0;
      push_data_q <= '0;
      push_vld_q <= 1'b0;
      hold_protocol_enable_q <= 1'b0;
    end else begin
      xlate_q <= xlate_d;
      xlate_vld_q <= xlate_vld_d;
      push_data_q <= push_data_d;
      push_vld_q <= push_vld_d;
      hold_protocol_enable_q <= hold_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_req(logic [6:0] sel, logic [7:0] da);
    core_req && (wsr_q[6:0] == sel) && (core_addr == da);
  endsequence

  sequence s_ans(logic [15:0] ma);
    xlate_vld_q && xlate_q.hit && (xlate_q.addr == ma);
  endsequence

  property p_rq1;
    core_req |=> xlate_vld_q ##1 (!xlate_vld_q || $past(core_req));
  endproperty
  a_rq1: assert property (p_rq1) // RQ1
    else $error("translation answer missing");

  property p_rq2;
    core_req && wsr_q[6]
      |=> xlate_q.size == RWS_W32
          && xlate_q.hit == ($past(core_addr) >= 8'hE0);
  endproperty
  a_rq2: assert property (p_rq2) // RQ2
    else $error("32-byte window decode wrong");

  property p_rq3;
    core_req && (wsr_q[6:5] == 2'b01)
      |=> xlate_q.size == RWS_W64
          && xlate_q.hit == ($past(core_addr) >= 8'hC0);
  endproperty
  a_rq3: assert property (p_rq3) // RQ3
    else $error("64-byte window decode wrong");

  property p_rq4;
    core_req && (wsr_q[6:4] == 3'b001)
      |=> xlate_q.size == RWS_W128
          && xlate_q.hit == ($past(core_addr) >= 8'h80);
  endproperty
  a_rq4: assert property (p_rq4) // RQ4
    else $error("128-byte window decode wrong");

  property p_rq5;
    (s_req(7'h70, 8'hE0) or s_req(7'h38, 8'hC0)
      or s_req(7'h1C, 8'h80)) |=> s_ans(16'h1E00);
  endproperty
  a_rq5: assert property (p_rq5) // RQ5
    else $error("1E00H not reached through window");

  property p_rq6;
    (s_req(7'h7D, 8'hEC) or s_req(7'h3E, 8'hEC)
      or s_req(7'h1F, 8'hAC)) |=> s_ans(16'h1FAC);
  endproperty
  a_rq6: assert property (p_rq6) // RQ6
    else $error("1FACH not reached through window");

  property p_rq7;
    (s_req(7'h72, 8'hEF) or s_req(7'h39, 8'hCF)
      or s_req(7'h1C, 8'hCF)) |=> s_ans(16'h1E4F);
  endproperty
  a_rq7: assert property (p_rq7) // RQ7
    else $error("1E4FH not reached through window");

  property p_rq8;
    core_req && core_addr[7] ##1 core_req
      && (wsr_q[6:0] == $past(wsr_q[6:0])) && $changed(wsr_q[7])
      && (core_addr == $past(core_addr))
      |=> xlate_q == $past(xlate_q);
  endproperty
  a_rq8: assert property (p_rq8) // RQ8
    else $error("hold bit altered the mapping");

  property p_rq8_hold;
    $changed(wsr_q[HOLD_BIT])
      |=> hold_protocol_enable_q == (HOLD_PRESENT && $past(wsr_q[7]));
  endproperty
  a_rq8_hold: assert property (p_rq8_hold) // RQ8
    else $error("hold enable output not following bit 7");

  property p_rq9;
    !HOLD_PRESENT |-> !wsr_q[HOLD_BIT] && !hold_protocol_enable_q;
  endproperty
  a_rq9: assert property (p_rq9) // RQ9
    else $error("reserved bit 7 became set");

  property p_rq10;
    push_all_instr |=> push_vld_q && push_data_q == $past(wsr_q)
      ##1 (push_vld_q || push_data_q == $past(push_data_q));
  endproperty
  a_rq10: assert property (p_rq10) // RQ10
    else $error("push did not save window select");

  property p_rq11;
    core_req && (wsr_q[6:4] != 3'b000) && core_addr[7]
      && (core_addr[6:5] == 2'b11)
      |=> xlate_q.hit && xlate_q.addr[15:11] == 5'b00011
          && xlate_q.addr[4:0] == $past(core_addr[4:0]);
  endproperty
  a_rq11: assert property (p_rq11) // RQ11
    else $error("mapped address formula broken");

  property p_rq12;
    core_req && (wsr_q[6:4] == 3'b000)
      |=> !xlate_q.hit && xlate_q.addr == {8'h00, $past(core_addr)};
  endproperty
  a_rq12: assert property (p_rq12) // RQ12
    else $error("address mapped with no window selected");

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not a single pulse");

  property p_wb_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
      && wb_adr_i == WSR_OFS && wb_sel_i[0] && !pop_all_instr
      |=> wsr_q[6:0] == $past(wb_dat_i[6:0]);
  endproperty
  a_wb_wr: assert property (p_wb_wr)
    else $error("register write lost");

endmodule : rws_top

// [tb/rws_core_model.sv]
// Purpose: core side model issuing window requests
// Assumes: one request in flight at a time
// Notes: released lines show inverted data, never stale

`timescale 1ns/1ps

module rws_core_model (
  input wire logic mclk,
  output logic core_req,
  output logic [7:0] core_addr,
  output logic push_all_instr,
  output logic pop_all_instr,
  output logic [7:0] pop_data
);
  initial begin
    core_req = 1'b0;
    core_addr = 8'h00;
    push_all_instr = 1'b0;
    pop_all_instr = 1'b0;
    pop_data = 8'h00;
  end
  task automatic xlate(input logic [7:0] a);
    @(posedge mclk);
    core_req <= 1'b1;
    core_addr <= a;
    @(posedge mclk);
    core_req <= 1'b0;
    core_addr <= ~a;
  endtask : xlate
  task automatic push();
    @(posedge mclk);
    push_all_instr <= 1'b1;
    @(posedge mclk);
    push_all_instr <= 1'b0;
  endtask : push
  task automatic pop(input logic [7:0] d);
    @(posedge mclk);
    pop_all_instr <= 1'b1;
    pop_data <= d;
    @(posedge mclk);
    pop_all_instr <= 1'b0;
    pop_data <= ~d;
  endtask : pop
endmodule : rws_core_model

// [tb/rws_tb_top.sv]
// Purpose: self-checking bench of the window select block
// Assumes: hold support present
// Notes: expected addresses are fixed selector and address pairs

`timescale 1ns/1ps

module register_window_select_tb_top;
  import rws_pkg::*;
  logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic core_req, xlate_vld_q, push_all_instr, pop_all_instr;
  logic push_vld_q, hold_protocol_enable_q;
  logic [7:0] core_addr, pop_data, push_data_q, window_select_reg;
  rws_xlate_s xlate_q;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  // selector, direct address, memory address
  logic [31:0] tab [11] = '{32'h70E01E00, 32'h38C01E00,
    32'h1C801E00, 32'h7DEC1FAC, 32'h3EEC1FAC, 32'h1FAC1FAC,
    32'h72EF1E4F, 32'h39CF1E4F, 32'h1CCF1E4F, 32'h0FE000E0,
    32'h1C7F007F};

  rws_top i_rws_top (.mclk(mclk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .core_req(core_req), .core_addr(core_addr),
    .xlate_q(xlate_q), .xlate_vld_q(xlate_vld_q),
    .push_all_instr(push_all_instr), .pop_all_instr(pop_all_instr),
    .pop_data(pop_data), .push_data_q(push_data_q),
    .push_vld_q(push_vld_q),
    .hold_protocol_enable_q(hold_protocol_enable_q),
    .window_select_reg(window_select_reg));
  rws_core_model i_rws_core_model (.mclk(mclk), .core_req(core_req),
    .core_addr(core_addr), .push_all_instr(push_all_instr),
    .pop_all_instr(pop_all_instr), .pop_data(pop_data));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      close_out();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask : wb
  function automatic rws_size_e sz(input logic [7:0] s);
    return s[6] ? RWS_W32 : s[5] ? RWS_W64 : s[4] ? RWS_W128 : RWS_NONE;
  endfunction : sz
  function automatic logic [7:0] bs(input rws_size_e z);
    return z == RWS_W32 ? BASE_32 : z == RWS_W64 ? BASE_64 :
           z == RWS_W128 ? BASE_128 : 8'h00;
  endfunction : bs
  task automatic look(input logic [7:0] a, input logic [15:0] ea,
                      input logic eh, input rws_size_e es);
    i_rws_core_model.xlate(a);
    @(negedge mclk);
    chk("vld", 1, xlate_vld_q);
    chk("hit", eh, xlate_q.hit);
    chk("addr", ea, xlate_q.addr);
    if (eh) chk("size", es, xlate_q.size);
    // valid stands for one cycle only
    @(negedge mclk);
    chk("vld_drop", 0, xlate_vld_q);
    chk("addr_hold", ea, xlate_q.addr);
  endtask : look

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    wb(0, WSR_OFS, 0, 4'hF);
    chk("wsr", 0, rd);
    wb(0, STAT_OFS, 0, 4'hF);
    chk("stat", 0, rd);
    wb(0, 8'h20, 0, 4'hF);
    chk("unmapped", 0, rd);
    chk("hold", 0, hold_protocol_enable_q);
  endtask : t_reset
  task automatic t_table();
    logic [7:0] s;
    for (int i = 0; i < 11; i++) begin
      s = tab[i][31:24];
      wb(1, WSR_OFS, {24'h0, s}, 4'hF);
      look(tab[i][23:16], tab[i][15:0], tab[i][15:8] != 0, sz(s));
      wb(0, STAT_OFS, 0, 4'hF);
      chk("stat", {16'h0, bs(sz(s)), 6'h0, sz(s)}, rd);
    end
  endtask : t_table
  task automatic t_hold();
    wb(1, WSR_OFS, 32'hF0, 4'hF);
    look(8'hE0, 16'h1E00, 1, RWS_W32);
    chk("hold", 1, hold_protocol_enable_q);
    wb(1, WSR_OFS, 32'h39, 4'hE);
    wb(0, WSR_OFS, 0, 4'hF);
    chk("wsr", 32'hF0, rd);
    wb(1, WSR_OFS, 32'h70, 4'hF);
    look(8'hE0, 16'h1E00, 1, RWS_W32);
    chk("hold", 0, hold_protocol_enable_q);
  endtask : t_hold
  task automatic t_push_pop();
    wb(1, WSR_OFS, 32'h38, 4'hF);
    i_rws_core_model.push();
    @(negedge mclk);
    chk("push_vld", 1, push_vld_q);
    chk("push_data", 8'h38, push_data_q);
    i_rws_core_model.pop(8'h1C);
    @(negedge mclk);
    chk("wsr", 8'h1C, window_select_reg);
    look(8'hCF, 16'h1E4F, 1, RWS_W128);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk("wsr", 0, window_select_reg);
  endtask : t_push_pop

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #400000;
    err_count++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_table();
    t_hold();
    t_push_pop();
    close_out();
  end
endmodule : register_window_select_tb_top
